// *** hw/cam_port_pkg.sv ***
// Shared constants and types for the CAM host control port
// Summary of operation
// - In hardware control, address-valid low means direct array address
// - Validity line written on writes, driven on reads
// - Selected by either chip select or page match
// - Mode field zero selects hardware control
// - Half select picks low or high word
// - Hardware control: mask lines and opcode lines
// - Software mode loads instruction from data bus
// - Data bit 13 stands in for write enable
// - Dataless instruction executes in its load cycle
// - Data instructions wait for address-valid-low cycle
// - Loaded instruction repeats on later data cycles
// - Software control read returns status word
// - Only priority-winning device, or last device on a miss, drives status after compare
// - Status after access from any selected device
// - Host follows instruction with matching cycle type
// - Host alternates comparand writes and status reads
// - Host drives address-valid from its decode
// - Result bus shows latest address-changing result
// - After compare, only highest-priority matching device, or last device on a miss, drives result
// - Lowest-priority device drives all ones on miss
// - Host may use only half select, opcodes
// - Result bus released by enable, latched while chip enabled
// - Match flag passes down the priority chain
package cam_port_pkg;
	localparam int DQ_W   = 32;
	localparam int AC_W   = 13;
	localparam int AA_W   = 13;
	localparam int PAGE_W = 4;
	localparam int RES_W  = PAGE_W + AA_W;
	localparam int CODE_W = 12;

	localparam logic [1:0] MODE_SW = 2'h3;
	localparam int CFG_MASK_LSB   = 29;
	localparam int CFG_MODE_LSB   = 26;
	localparam int CFG_LAST_BIT   = 25;
	localparam int CFG_PAGE_LSB   = 0;
	localparam int DEVSEL_EN_BIT  = 4;
	localparam int INSTR_DIR_BIT  = 13;
	localparam int INSTR_HALF_BIT = 12;
	localparam int MASK_LSB       = 6;

	localparam logic [31:0] CFG_RESET    = 32'h0000_0000;
	localparam logic [31:0] DEVSEL_RESET = 32'h0000_0010;
	localparam logic [31:0] ADDR_RESET   = 32'h0000_0000;

	localparam logic [1:0] SRC_RESET  = 2'h0;
	localparam logic [1:0] SRC_MATCH  = 2'h1;
	localparam logic [1:0] SRC_ACCESS = 2'h2;

	localparam int READ_LATENCY = 2;

	localparam logic [5:0] OP_RW_MEM    = 6'h01;
	localparam logic [5:0] OP_RD_VALID  = 6'h02;
	localparam logic [5:0] OP_RW_CFG    = 6'h03;
	localparam logic [5:0] OP_RW_DEVSEL = 6'h04;
	localparam logic [5:0] OP_RW_ADDR   = 6'h05;
	localparam logic [5:0] OP_WR_PAGE   = 6'h06;
	localparam logic [5:0] OP_CMP_DQ    = 6'h07;
	localparam logic [5:0] OP_RD_STATUS = 6'h08;
	localparam logic [5:0] OP_INC_ADDR  = 6'h09;
	localparam logic [5:0] OP_DEC_ADDR  = 6'h0a;

	typedef enum logic [3:0] {
		K_NONE, K_MEM, K_VALID, K_CFG, K_DEVSEL, K_ADDR,
		K_PAGE, K_CMP, K_STATUS, K_INC, K_DEC
	} op_kind_t;

	typedef enum logic [1:0] {H_IDLE, H_DRIVE, H_WAIT1, H_WAIT2} host_state_t;
endpackage

// *** hw/cam_bus_if.sv ***
// Parallel bus between the host and the CAM device
interface cam_bus_if;
	import cam_port_pkg::*;
	logic              chip_enable_n;
	logic              chip_select_a_n;
	logic              chip_select_b_n;
	logic              write_enable_n;
	logic              output_enable_n;
	logic              addr_or_ctrl_select;
	logic              word_half_select;
	logic [AC_W-1:0]   ctrl_address_bus;
	logic [DQ_W-1:0]   host_dq_o;
	logic              host_dq_oe;
	logic [DQ_W-1:0]   dev_dq_o;
	logic              dev_dq_oe;
	logic [DQ_W-1:0]   host_data_bus;
	logic              host_vb_o;
	logic              host_vb_oe;
	logic              dev_vb_o;
	logic              dev_vb_oe;
	logic              entry_validity_line;
	logic [RES_W-1:0]  result_address_bus;
	logic              result_oe;
	logic              match_chain_in_n;
	logic              match_flag_out_n;

	// Undriven wires settle low, validity line floats high (empty)
	assign host_data_bus = dev_dq_oe ? dev_dq_o : (host_dq_oe ? host_dq_o : '0);
	assign entry_validity_line = dev_vb_oe ? dev_vb_o : (host_vb_oe ? host_vb_o : 1'b1);

	modport device (
		input  chip_enable_n, chip_select_a_n, chip_select_b_n, write_enable_n,
		input  output_enable_n, addr_or_ctrl_select, word_half_select, ctrl_address_bus,
		input  host_data_bus, entry_validity_line, match_chain_in_n,
		output dev_dq_o, dev_dq_oe, dev_vb_o, dev_vb_oe,
		output result_address_bus, result_oe, match_flag_out_n
	);
	modport host (
		output chip_enable_n, chip_select_a_n, chip_select_b_n, write_enable_n,
		output output_enable_n, addr_or_ctrl_select, word_half_select, ctrl_address_bus,
		output host_dq_o, host_dq_oe, host_vb_o, host_vb_oe, match_chain_in_n,
		input  host_data_bus, entry_validity_line,
		input  result_address_bus, result_oe, match_flag_out_n
	);
endinterface

// *** hw/cam_op_decode.sv ***
// Opcode classifier shared by both control modes
module cam_op_decode
	import cam_port_pkg::*;
(
	// Opcode in
	input  wire logic [5:0] opcode,
	// Classification out
	output op_kind_t        kind,
	output logic            uses_data
);
	always_comb begin
		case (opcode)
			OP_RW_MEM:    kind = K_MEM;
			OP_RD_VALID:  kind = K_VALID;
			OP_RW_CFG:    kind = K_CFG;
			OP_RW_DEVSEL: kind = K_DEVSEL;
			OP_RW_ADDR:   kind = K_ADDR;
			OP_WR_PAGE:   kind = K_PAGE;
			OP_CMP_DQ:    kind = K_CMP;
			OP_RD_STATUS: kind = K_STATUS;
			OP_INC_ADDR:  kind = K_INC;
			OP_DEC_ADDR:  kind = K_DEC;
			default:      kind = K_NONE;
		endcase
		// Memory, register, validity and page ops move data
		uses_data = !(kind == K_NONE || kind == K_INC || kind == K_DEC);
	end
endmodule

// *** hw/cam_device_end.sv ***
// Device end: bus decode, control modes, status and result bus
module cam_device_end
	import cam_port_pkg::*;
(
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            rstn,
	// Host bus
	cam_bus_if.device            bus,
	// Array access
	output logic                 mem_req,
	output logic                 mem_we,
	output logic [AA_W-1:0]      mem_addr,
	output logic                 mem_wvalid_n,
	output logic                 cmp_req,
	output logic                 arr_half,
	output logic [2:0]           arr_mask_sel,
	output logic [DQ_W-1:0]      arr_data,
	// Array answers, valid while a request stands
	input  wire logic [DQ_W-1:0] mem_rdata,
	input  wire logic            mem_rvalid_n,
	input  wire logic            cmp_hit,
	input  wire logic            cmp_multi,
	input  wire logic [AA_W-1:0] cmp_addr,
	input  wire logic            table_full_n
);
	typedef struct packed {
		logic [31:0]      cfg;
		logic [31:0]      devsel;
		logic [31:0]      addr;
		logic [13:0]      instr;
		logic             p_go;
		logic             p_read;
		op_kind_t         p_kind;
		logic [DQ_W-1:0]  p_rdata;
		logic             mem_req;
		logic             mem_we;
		logic [AA_W-1:0]  mem_addr;
		logic             mem_wvalid_n;
		logic             cmp_req;
		logic             arr_half;
		logic [2:0]       arr_mask_sel;
		logic [DQ_W-1:0]  arr_data;
		logic [DQ_W-1:0]  dq_o;
		logic             dq_oe;
		logic             vb_o;
		logic             vb_oe;
		logic             hit;
		logic             multi;
		logic [1:0]       src;
		logic [RES_W-1:0] res_val;
		logic [RES_W-1:0] res_pend;
		logic             res_pend_f;
		logic             res_oe;
		logic             chain_q;
		logic             mf_n;
	} dev_state_t;

	dev_state_t s;
	dev_state_t n;

	logic [PAGE_W-1:0] page;
	logic              sw;
	logic              sel;
	logic              cyc;
	logic              wr;
	logic              av;
	logic              load_cyc;
	logic              stat_cyc;
	logic              direct;
	logic [CODE_W-1:0] code;
	op_kind_t          kind;
	logic              uses_data;
	op_kind_t          ex_kind;
	logic              ex_go;
	logic              ex_wr;
	logic              ex_half;
	logic [RES_W-1:0]  aa_now;
	logic [DQ_W-1:0]   status_word;
	logic              match_drv;
	logic [DQ_W-1:0]   dq;

	assign dq   = bus.host_data_bus;
	assign page = s.cfg[CFG_PAGE_LSB +: PAGE_W];
	assign sw   = s.cfg[CFG_MODE_LSB +: 2] == MODE_SW;
	assign sel  = !bus.chip_select_a_n || !bus.chip_select_b_n
		|| (!s.devsel[DEVSEL_EN_BIT] && s.devsel[PAGE_W-1:0] == page);
	assign cyc  = !bus.chip_enable_n && sel;
	assign wr   = !bus.write_enable_n;
	assign av   = bus.addr_or_ctrl_select;
	assign direct   = cyc && !sw && !av;
	assign load_cyc = cyc && sw && av && wr;
	assign stat_cyc = cyc && sw && av && !wr;
	// Control code from bus, from data lines at load, or held instruction
	assign code = load_cyc ? dq[CODE_W-1:0]
		: (sw ? s.instr[CODE_W-1:0] : bus.ctrl_address_bus[CODE_W-1:0]);

	cam_op_decode u_dec (
		.opcode    (code[5:0]),
		.kind      (kind),
		.uses_data (uses_data)
	);

	assign ex_kind = stat_cyc ? K_STATUS : (direct ? K_MEM : kind);
	assign ex_go   = direct || (cyc && !sw && av) || stat_cyc
		|| (load_cyc && !uses_data)
		|| (cyc && sw && !av);
	assign ex_wr   = load_cyc ? !dq[INSTR_DIR_BIT] : wr;
	assign ex_half = load_cyc ? dq[INSTR_HALF_BIT]
		: (sw ? s.instr[INSTR_HALF_BIT] : bus.word_half_select);

	assign aa_now = s.res_pend_f ? s.res_pend : s.res_val;
	assign status_word = {1'b0, !s.hit, !s.multi, table_full_n, 2'h0, s.src,
		4'h0, page, 3'h0, aa_now[AA_W-1:0]};
	// Chain high means nobody above matched
	assign match_drv = s.chain_q && (s.hit || s.cfg[CFG_LAST_BIT]);

	always_comb begin
		n = s;
		n.mem_req = 1'b0;
		n.cmp_req = 1'b0;
		n.p_go    = 1'b0;
		n.dq_oe   = 1'b0;
		n.vb_oe   = 1'b0;
		if (load_cyc) begin
			n.instr = dq[13:0];
		end
		// First stage: issue the operation
		if (ex_go) begin
			n.p_go    = 1'b1;
			n.p_kind  = ex_kind;
			n.p_read  = !ex_wr;
			n.p_rdata = '0;
			case (ex_kind)
				K_MEM, K_VALID: begin
					n.mem_req      = 1'b1;
					n.mem_we       = ex_wr && ex_kind == K_MEM;
					n.mem_addr     = direct ? bus.ctrl_address_bus : s.addr[AA_W-1:0];
					n.arr_half     = ex_half;
					n.arr_mask_sel = direct ? s.cfg[CFG_MASK_LSB +: 3] : code[MASK_LSB +: 3];
					n.arr_data     = dq;
					n.mem_wvalid_n = bus.entry_validity_line;
				end
				K_CFG: begin
					if (ex_wr) n.cfg = dq;
					else n.p_rdata = s.cfg;
				end
				K_DEVSEL: begin
					if (ex_wr) n.devsel = dq;
					else n.p_rdata = s.devsel;
				end
				K_ADDR: begin
					if (ex_wr) n.addr = dq;
					else n.p_rdata = s.addr;
				end
				K_PAGE: begin
					if (ex_wr) n.cfg[CFG_PAGE_LSB +: PAGE_W] = dq[PAGE_W-1:0];
				end
				K_CMP: begin
					n.cmp_req      = 1'b1;
					n.arr_half     = ex_half;
					n.arr_mask_sel = code[MASK_LSB +: 3];
					n.arr_data     = dq;
					n.p_read       = 1'b0;
				end
				K_STATUS: begin
					n.p_read  = 1'b1;
					n.p_rdata = status_word;
				end
				K_INC: begin
					n.addr[AA_W-1:0] = s.addr[AA_W-1:0] + 13'h0001;
					n.p_read = 1'b0;
				end
				K_DEC: begin
					n.addr[AA_W-1:0] = s.addr[AA_W-1:0] - 13'h0001;
					n.p_read = 1'b0;
				end
				default: n.p_go = 1'b0;
			endcase
		end
		// Result moves to the pins only between cycles
		if (s.res_pend_f && bus.chip_enable_n) begin
			n.res_val    = s.res_pend;
			n.res_pend_f = 1'b0;
		end
		// Second stage: array answers and read data
		if (s.p_go) begin
			case (s.p_kind)
				K_MEM, K_VALID: begin
					n.src        = SRC_ACCESS;
					n.res_pend   = {page, s.mem_addr};
					n.res_pend_f = 1'b1;
					if (s.p_read) begin
						n.dq_oe = 1'b1;
						n.vb_oe = 1'b1;
						n.vb_o  = mem_rvalid_n;
						n.dq_o  = s.p_kind == K_MEM ? mem_rdata : {31'h0000_0000, mem_rvalid_n};
					end
				end
				K_CMP: begin
					n.hit        = cmp_hit;
					n.multi      = cmp_multi;
					n.src        = SRC_MATCH;
					n.res_pend   = cmp_hit ? {page, cmp_addr} : '1;
					n.res_pend_f = 1'b1;
				end
				K_STATUS: begin
					n.dq_o  = s.p_rdata;
					n.dq_oe = s.src != SRC_MATCH || match_drv;
				end
				default: begin
					n.dq_o  = s.p_rdata;
					n.dq_oe = s.p_read;
				end
			endcase
		end
		n.chain_q = bus.match_chain_in_n;
		n.mf_n    = !(s.hit || !s.chain_q);
		// Stays off unless this device won the last result
		n.res_oe  = !bus.output_enable_n
			&& (s.src == SRC_ACCESS || (s.src == SRC_MATCH && match_drv));
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s         <= '0;
			s.cfg     <= CFG_RESET;
			s.devsel  <= DEVSEL_RESET;
			s.addr    <= ADDR_RESET;
			s.src     <= SRC_RESET;
			s.chain_q <= 1'b1;
			s.mf_n    <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign bus.dev_dq_o           = s.dq_o;
	assign bus.dev_dq_oe          = s.dq_oe;
	assign bus.dev_vb_o           = s.vb_o;
	assign bus.dev_vb_oe          = s.vb_oe;
	assign bus.result_address_bus = s.res_val;
	assign bus.result_oe          = s.res_oe;
	assign bus.match_flag_out_n   = s.mf_n;
	assign mem_req      = s.mem_req;
	assign mem_we       = s.mem_we;
	assign mem_addr     = s.mem_addr;
	assign mem_wvalid_n = s.mem_wvalid_n;
	assign cmp_req      = s.cmp_req;
	assign arr_half     = s.arr_half;
	assign arr_mask_sel = s.arr_mask_sel;
	assign arr_data     = s.arr_data;
endmodule

// *** hw/cam_host_end.sv ***
// Host end: turns user commands into framed bus cycles
module cam_host_end
	import cam_port_pkg::*;
(
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            rstn,
	// Device bus
	cam_bus_if.host              bus,
	// Command
	input  wire logic            cmd_valid,
	output logic                 cmd_ready,
	input  wire logic            cmd_write,
	input  wire logic            cmd_ctrl,
	input  wire logic            cmd_half,
	input  wire logic [AC_W-1:0] cmd_ac,
	input  wire logic [DQ_W-1:0] cmd_data,
	input  wire logic            cmd_vb,
	input  wire logic            cmd_use_select,
	// Static system levels
	input  wire logic            result_enable,
	input  wire logic            chain_in_n,
	// Response
	output logic                 rsp_valid,
	output logic [DQ_W-1:0]      rsp_data,
	output logic                 rsp_vb
);
	typedef struct packed {
		host_state_t     st;
		logic            ready;
		logic            is_read;
		logic            ce_n;
		logic            cs_a_n;
		logic            we_n;
		logic            oe_n;
		logic            av;
		logic            half;
		logic [AC_W-1:0] ac;
		logic [DQ_W-1:0] dq_o;
		logic            dq_oe;
		logic            vb_o;
		logic            vb_oe;
		logic            chain_n;
		logic            rsp_valid;
		logic [DQ_W-1:0] rsp_data;
		logic            rsp_vb;
	} host_reg_t;

	host_reg_t s;
	host_reg_t n;

	always_comb begin
		n = s;
		n.rsp_valid = 1'b0;
		n.oe_n      = !result_enable;
		n.chain_n   = chain_in_n;
		case (s.st)
			H_IDLE: begin
				if (cmd_valid && s.ready) begin
					n.st      = H_DRIVE;
					n.ready   = 1'b0;
					n.is_read = !cmd_write;
					n.ce_n    = 1'b0;
					// One chip select only, so one device answers
					n.cs_a_n  = !cmd_use_select;
					n.we_n    = !cmd_write;
					n.av      = cmd_ctrl;
					n.half    = cmd_half;
					n.ac      = cmd_ac;
					n.dq_o    = cmd_data;
					n.dq_oe   = cmd_write;
					n.vb_o    = cmd_vb;
					n.vb_oe   = cmd_write && !cmd_ctrl;
				end
			end
			H_DRIVE: begin
				n.st    = H_WAIT1;
				n.ce_n  = 1'b1;
				n.cs_a_n = 1'b1;
				n.we_n  = 1'b1;
				n.dq_oe = 1'b0;
				n.vb_oe = 1'b0;
			end
			H_WAIT1: n.st = H_WAIT2;
			H_WAIT2: begin
				// Read data arrives two edges after the sampling edge
				n.st        = H_IDLE;
				n.ready     = 1'b1;
				n.rsp_valid = s.is_read;
				n.rsp_data  = bus.host_data_bus;
				n.rsp_vb    = bus.entry_validity_line;
			end
			default: n.st = H_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s         <= '0;
			s.ready   <= 1'b1;
			s.ce_n    <= 1'b1;
			s.cs_a_n  <= 1'b1;
			s.we_n    <= 1'b1;
			s.oe_n    <= 1'b1;
			s.chain_n <= 1'b1;
			s.vb_o    <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign bus.chip_enable_n       = s.ce_n;
	assign bus.chip_select_a_n     = s.cs_a_n;
	assign bus.chip_select_b_n     = 1'b1;
	assign bus.write_enable_n      = s.we_n;
	assign bus.output_enable_n     = s.oe_n;
	assign bus.addr_or_ctrl_select = s.av;
	assign bus.word_half_select    = s.half;
	assign bus.ctrl_address_bus    = s.ac;
	assign bus.host_dq_o           = s.dq_o;
	assign bus.host_dq_oe          = s.dq_oe;
	assign bus.host_vb_o           = s.vb_o;
	assign bus.host_vb_oe          = s.vb_oe;
	assign bus.match_chain_in_n    = s.chain_n;
	assign cmd_ready = s.ready;
	assign rsp_valid = s.rsp_valid;
	assign rsp_data  = s.rsp_data;
	assign rsp_vb    = s.rsp_vb;
endmodule

// *** verification/cam_port_chk.sv ***
// Protocol checker for the bus between host end and device end
module cam_port_chk
	import cam_port_pkg::*;
(
	// Clock and reset
	input wire logic             clk,
	input wire logic             rstn,
	// Host side strobes and drives
	input wire logic             chip_enable_n,
	input wire logic             write_enable_n,
	input wire logic             output_enable_n,
	input wire logic             addr_or_ctrl_select,
	input wire logic             host_dq_oe,
	input wire logic             host_vb_oe,
	input wire logic             match_chain_in_n,
	// Device side drives
	input wire logic             dev_dq_oe,
	input wire logic             dev_vb_oe,
	input wire logic [RES_W-1:0] result_address_bus,
	input wire logic             result_oe,
	input wire logic             match_flag_out_n
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	AST_OE_RELEASE: assert property (output_enable_n |=> !result_oe)
		else $error("result bus enabled while output enable high");
	AST_RESULT_LATCHED: assert property (!chip_enable_n |=> $stable(result_address_bus))
		else $error("result bus changed while chip enable low");
	// Device answers are seen two edges after the taking edge
	AST_DQ_CAUSE: assert property (dev_dq_oe |-> $past(!chip_enable_n && write_enable_n, 2))
		else $error("device drove data without a read cycle");
	AST_VB_CAUSE: assert property (dev_vb_oe |->
		$past(!chip_enable_n && write_enable_n && !addr_or_ctrl_select, 2))
		else $error("device drove validity without an array read");
	AST_WR_DATA: assert property (!chip_enable_n && !write_enable_n |-> host_dq_oe)
		else $error("write cycle without host data");
	AST_RD_NODRIVE: assert property (!chip_enable_n && write_enable_n |-> !host_dq_oe)
		else $error("host drove data during a read");
	AST_WR_VALIDITY: assert property (!chip_enable_n && !write_enable_n &&
		!addr_or_ctrl_select |-> host_vb_oe)
		else $error("array write without validity drive");
	AST_CHAIN_PASS: assert property (!match_chain_in_n |-> ##2 !match_flag_out_n)
		else $error("upstream match not passed down the chain");
	AST_RESET_STATE: assert property ($rose(rstn) |->
		!result_oe && !dev_dq_oe && match_flag_out_n)
		else $error("outputs active right after reset");
endmodule

// *** verification/test_cam_host_control_port.sv ***
// Testbench joining host end and device end over the bus
module test_cam_host_control_port
	import cam_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [DQ_W-1:0] KEY    = 32'ha5c3_0f96;
	localparam logic [AA_W-1:0] CMP_AT = 13'h0123;

	logic            clk;
	logic            rstn;
	logic            cmd_valid;
	logic            cmd_ready;
	logic            cmd_write;
	logic            cmd_ctrl;
	logic            cmd_half;
	logic            cmd_vb;
	logic            cmd_use_select;
	logic [AC_W-1:0] cmd_ac;
	logic [DQ_W-1:0] cmd_data;
	logic [DQ_W-1:0] rsp_data;
	logic [DQ_W-1:0] got;
	logic            rsp_valid;
	logic            rsp_vb;
	logic            got_vb;
	logic            result_enable;
	logic            chain_in_n;
	logic            mem_req;
	logic            mem_we;
	logic            mem_wvalid_n;
	logic            cmp_req;
	logic            arr_half;
	logic [AA_W-1:0] mem_addr;
	logic [2:0]      arr_mask_sel;
	logic [DQ_W-1:0] arr_data;
	logic [4:0]      idx;
	logic [DQ_W-1:0] arr [32];
	logic            vbits [32];
	int              n_errors;
	int              tests_run;

	cam_bus_if bus ();

	cam_host_end u_cam_host_end (.clk, .rstn, .bus(bus), .cmd_valid, .cmd_ready, .cmd_write,
		.cmd_ctrl, .cmd_half, .cmd_ac, .cmd_data, .cmd_vb, .cmd_use_select, .result_enable,
		.chain_in_n, .rsp_valid, .rsp_data, .rsp_vb);

	// Small array stand-in: 16 words per half, hit only on the fixed key
	assign idx = {arr_half, mem_addr[3:0]};
	cam_device_end u_cam_device_end (.clk, .rstn, .bus(bus), .mem_req, .mem_we, .mem_addr,
		.mem_wvalid_n, .cmp_req, .arr_half, .arr_mask_sel, .arr_data, .mem_rdata(arr[idx]),
		.mem_rvalid_n(vbits[idx]), .cmp_hit(arr_data == KEY), .cmp_multi(1'h0),
		.cmp_addr(CMP_AT), .table_full_n(1'h1));

	cam_port_chk u_cam_port_chk (.clk, .rstn, .chip_enable_n(bus.chip_enable_n),
		.write_enable_n(bus.write_enable_n), .output_enable_n(bus.output_enable_n),
		.addr_or_ctrl_select(bus.addr_or_ctrl_select), .host_dq_oe(bus.host_dq_oe),
		.host_vb_oe(bus.host_vb_oe), .match_chain_in_n(bus.match_chain_in_n),
		.dev_dq_oe(bus.dev_dq_oe), .dev_vb_oe(bus.dev_vb_oe),
		.result_address_bus(bus.result_address_bus), .result_oe(bus.result_oe),
		.match_flag_out_n(bus.match_flag_out_n));

	always @(posedge clk) begin
		if (mem_req && mem_we) begin
			arr[idx] <= arr_data;
			vbits[idx] <= mem_wvalid_n;
		end
	end

	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	task automatic wrap_up;
		$display("compares %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input logic [DQ_W-1:0] seen, input logic [DQ_W-1:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Entered just after an edge with ready high; returns once ready is back
	task automatic xfer(input logic w, input logic c, input logic h,
		input logic [AC_W-1:0] ac, input logic [DQ_W-1:0] d, input logic vb);
		int k;
		cmd_write = w;
		cmd_ctrl = c;
		cmd_half = h;
		cmd_ac = ac;
		cmd_data = d;
		cmd_vb = vb;
		cmd_valid = 1'h1;
		cyc(1);
		cmd_valid = 1'h0;
		for (k = 0; k < 20 && cmd_ready !== 1'h1; k++) begin
			cyc(1);
			if (rsp_valid === 1'h1) begin
				got = rsp_data;
				got_vb = rsp_vb;
			end
		end
		if (cmd_ready !== 1'h1) begin
			n_errors++;
			$display("FAIL %0t: command never completed", $time);
			wrap_up();
		end
	endtask

	task automatic wr(input logic c, input logic h, input logic [AC_W-1:0] ac,
		input logic [DQ_W-1:0] d, input logic vb);
		xfer(1'h1, c, h, ac, d, vb);
	endtask

	task automatic rd(input logic c, input logic h, input logic [AC_W-1:0] ac);
		xfer(1'h0, c, h, ac, 32'h0000_0000, 1'h1);
	endtask

	function automatic logic [AC_W-1:0] opc(input logic [2:0] m, input logic [5:0] op);
		return {4'h0, m, op};
	endfunction

	// Software instruction word: direction bit 13, half bit 12 left low
	task automatic load(input logic [5:0] op, input logic dir);
		wr(1'h1, 1'h0, 13'h0000, {18'h0_0000, dir, 7'h00, op}, 1'h1);
	endtask

	initial begin
		n_errors = 0;
		tests_run = 0;
		rstn = 1'h0;
		cmd_valid = 1'h0;
		cmd_write = 1'h0;
		cmd_ctrl = 1'h0;
		cmd_half = 1'h0;
		cmd_vb = 1'h1;
		cmd_ac = 13'h0000;
		cmd_data = 32'h0000_0000;
		cmd_use_select = 1'h1;
		result_enable = 1'h0;
		chain_in_n = 1'h1;
		for (int i = 0; i < 32; i++) begin
			arr[i] = 32'h0000_0000;
			vbits[i] = 1'h1;
		end
		repeat (3) @(posedge clk);
		#1;
		rstn = 1'h1;
		cyc(1);
		check(bus.result_oe, 1'h0);
		check(bus.match_flag_out_n, 1'h1);
		check(cmd_ready, 1'h1);
		$display("test reset done");

		result_enable = 1'h1;
		wr(1'h0, 1'h0, 13'h0005, 32'h1111_2222, 1'h0);
		wr(1'h0, 1'h1, 13'h0005, 32'h3333_4444, 1'h1);
		rd(1'h0, 1'h0, 13'h0005);
		check(got, 32'h1111_2222);
		check(got_vb, 1'h0);
		rd(1'h0, 1'h1, 13'h0005);
		check(got, 32'h3333_4444);
		check(got_vb, 1'h1);
		cyc(2);
		check(bus.result_address_bus, 32'h0000_0005);
		check(bus.result_oe, 1'h1);
		result_enable = 1'h0;
		cyc(3);
		check(bus.result_oe, 1'h0);
		result_enable = 1'h1;
		$display("test random access done");

		cmd_use_select = 1'h0;
		wr(1'h0, 1'h0, 13'h0005, 32'h5555_6666, 1'h0);
		cmd_use_select = 1'h1;
		rd(1'h0, 1'h0, 13'h0005);
		check(got, 32'h1111_2222);
		wr(1'h1, 1'h0, opc(3'h0, OP_RW_DEVSEL), 32'h0000_0000, 1'h1);
		cmd_use_select = 1'h0;
		wr(1'h0, 1'h0, 13'h0005, 32'h5555_6666, 1'h0);
		rd(1'h0, 1'h0, 13'h0005);
		check(got, 32'h5555_6666);
		cmd_use_select = 1'h1;
		$display("test select done");

		wr(1'h1, 1'h0, opc(3'h5, OP_CMP_DQ), KEY, 1'h1);
		cyc(2);
		check(arr_mask_sel, 3'h5);
		check(bus.result_address_bus, 32'h0000_0123);
		check(bus.result_oe, 1'h1);
		check(bus.match_flag_out_n, 1'h0);
		wr(1'h1, 1'h0, opc(3'h0, OP_CMP_DQ), ~KEY, 1'h1);
		cyc(2);
		check(bus.result_oe, 1'h0);
		check(bus.match_flag_out_n, 1'h1);
		wr(1'h1, 1'h0, opc(3'h0, OP_RW_CFG), 32'h0200_0000, 1'h1);
		wr(1'h1, 1'h0, opc(3'h0, OP_CMP_DQ), ~KEY, 1'h1);
		cyc(2);
		check(bus.result_address_bus, 32'h0001_ffff);
		check(bus.result_oe, 1'h1);
		chain_in_n = 1'h0;
		wr(1'h1, 1'h0, opc(3'h0, OP_CMP_DQ), KEY, 1'h1);
		cyc(2);
		check(bus.result_oe, 1'h0);
		chain_in_n = 1'h1;
		$display("test compare done");

		wr(1'h1, 1'h0, opc(3'h0, OP_RW_CFG), 32'h0c00_0000, 1'h1);
		load(OP_RW_ADDR, 1'h0);
		wr(1'h0, 1'h0, 13'h0000, 32'h0000_0009, 1'h1);
		load(OP_RW_MEM, 1'h0);
		wr(1'h0, 1'h0, 13'h0000, 32'h7777_8888, 1'h0);
		wr(1'h0, 1'h0, 13'h0000, 32'h9999_aaaa, 1'h0);
		load(OP_RW_MEM, 1'h1);
		rd(1'h0, 1'h0, 13'h0000);
		check(got, 32'h9999_aaaa);
		check(got_vb, 1'h0);
		rd(1'h1, 1'h0, 13'h0000);
		check({got[25:24], got[12:0]}, {2'h2, 13'h0009});
		rd(1'h0, 1'h0, 13'h0000);
		check(got, 32'h9999_aaaa);
		load(OP_INC_ADDR, 1'h0);
		load(OP_RW_ADDR, 1'h1);
		rd(1'h0, 1'h0, 13'h0000);
		check(got[12:0], 13'h000a);
		load(OP_RD_VALID, 1'h1);
		rd(1'h0, 1'h0, 13'h0000);
		check(got, 32'h0000_0001);
		check(got_vb, 1'h1);
		load(OP_DEC_ADDR, 1'h0);
		load(OP_RD_VALID, 1'h1);
		rd(1'h0, 1'h0, 13'h0000);
		check(got, 32'h0000_0000);
		check(got_vb, 1'h0);
		load(OP_WR_PAGE, 1'h0);
		wr(1'h0, 1'h0, 13'h0000, 32'h0000_0003, 1'h1);
		rd(1'h1, 1'h0, 13'h0000);
		check(got[19:16], 4'h3);
		load(OP_CMP_DQ, 1'h0);
		wr(1'h0, 1'h0, 13'h0000, KEY, 1'h1);
		rd(1'h1, 1'h0, 13'h0000);
		check({got[30], got[25:24], got[12:0]}, {1'h0, 2'h1, CMP_AT});
		// Miss on a device not last in chain: status stays undriven
		wr(1'h0, 1'h0, 13'h0000, ~KEY, 1'h1);
		rd(1'h1, 1'h0, 13'h0000);
		check(got, 32'h0000_0000);
		$display("test software control done");
		wrap_up();
	end
endmodule
